// ===== hw/rwcs_pkg.sv
// constants for the watchdog/alarm counter control, status and charger registers
// assumes a 40 MHz register clock; shared by the register module and the bench
package rwcs_pkg;
  // =========================================================
  // register map
  localparam logic [7:0] ADR_FIRST   = 8'h00;
  localparam logic [7:0] ADR_CNT0    = 8'h04;
  localparam logic [7:0] ADR_CNT2    = 8'h06;
  localparam logic [7:0] ADR_CONTROL = 8'h07;
  localparam logic [7:0] ADR_STATUS  = 8'h08;
  localparam logic [7:0] ADR_CHARGER = 8'h10;
  // =========================================================
  // reset values
  localparam logic [7:0]  CONTROL_RST = 8'h06;
  localparam logic [7:0]  CHARGER_RST = 8'h00;
  localparam logic        OSF_RST     = 1'b1;
  localparam logic [23:0] CNT_RST     = 24'h000000;
  // =========================================================
  // field positions
  localparam int CB_OSC_DIS = 7;
  localparam int CB_CNT_EN  = 6;
  localparam int CB_MODE    = 5;
  localparam int CB_BACKUP_SQUARE_WAVE_ENABLE   = 4;
  localparam int CB_STEER   = 3;
  localparam int CB_RATE_HI = 2;
  localparam int CB_RATE_LO = 1;
  localparam int CB_AIE     = 0;
  localparam int SB_OSF     = 7;
  localparam int SB_AF      = 0;
  // =========================================================
  // field codes
  localparam logic [3:0] UNLOCK_KEY  = 4'ha;
  localparam logic [1:0] DIODE_NONE  = 2'h1;
  localparam logic [1:0] DIODE_ONE   = 2'h2;
  localparam logic [1:0] RES_OFF     = 2'h0;
  localparam logic [1:0] RATE_1HZ    = 2'h0;
  localparam logic [1:0] RATE_4K     = 2'h1;
  localparam logic [1:0] RATE_8K     = 2'h2;
  localparam logic [6:0] SLAVE_ADDR  = 7'h68;
  localparam logic [3:0] BITS_BYTE   = 4'h8;
  // =========================================================
  // timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int SEC_S        = 1;
  localparam int WD_TICK_HZ   = 4096;
  localparam int PULSE_MS     = 250;
  localparam int SQW_HZ_1     = 1;
  localparam int SQW_HZ_4K    = 4096;
  localparam int SQW_HZ_8K    = 8192;
  localparam int SQW_HZ_32K   = 32768;
  localparam int SEC_CYC_DEF  = CLK_HZ * SEC_S;
  localparam int WD_CYC_DEF   = CLK_HZ / WD_TICK_HZ;
  localparam int PULSE_CYC_DEF = (CLK_HZ / 1000) * PULSE_MS;
  localparam int SQW1_HALF_DEF = CLK_HZ / (2 * SQW_HZ_1);
  localparam int SQW4K_HALF_DEF = CLK_HZ / (2 * SQW_HZ_4K);
  localparam int SQW8K_HALF   = CLK_HZ / (2 * SQW_HZ_8K);
  localparam int SQW32K_HALF  = CLK_HZ / (2 * SQW_HZ_32K);
endpackage

// ===== hw/rwcs_regs.sv
// control, status and charger registers with the watchdog/alarm down counter
// assumes scl/sda arrive as pins sampled on link_clk, vcc_good comes from the
// power monitor pin, and the bench resolves the open-drain wires from the enables

// Contract
// - oscillator stops on backup supply when disable bit is 1, else runs
// - on main supply the oscillator always runs
// - enable bit starts counter; cleared, the 24 counter bits are plain storage
// - periodic mode counts seconds, reloads from seed at zero and restarts
// - watchdog mode counts at 4096 Hz, sets alarm flag at zero and halts
// - in watchdog mode a counter byte access reloads seed and restarts
// - square wave keeps running on backup only when backup enable is 1
// - steer 0 in watchdog mode gives 250 ms low reset pulse at zero
// - steer 1 moves the 250 ms watchdog pulse to the interrupt output
// - rate select picks 1 Hz, 4.096, 8.192 or 32.768 kHz
// - in watchdog mode alarm flag starts interrupt only with irq enable and steer both 1
// - clearing irq enable does not shorten a running 250 ms pulse
// - power-up clears control bits except both rate bits set
// - oscillator stop sets stopped flag, held until software writes 0
// - counter zero sets alarm flag; write 0 clears, write 1 no effect
// - periodic mode with irq enable holds interrupt low until flag cleared
// - watchdog mode pulses interrupt 250 ms and clears flag at pulse end
// - writing 0 to alarm flag does not cut a running pulse short
// - charger enabled only when unlock nibble is 1010
// - diode code 01 no diode, 10 one diode, 00 and 11 disable
// - resistor code 01, 10, 11 select resistor; 00 disables
// - charger register resets to all zeros
// - pointer advances per byte and wraps to 00h after last location
module rwcs_regs
  import rwcs_pkg::*;
#(
  parameter int SEC_CYC    = SEC_CYC_DEF,
  parameter int WD_CYC     = WD_CYC_DEF,
  parameter int PULSE_CYC  = PULSE_CYC_DEF,
  parameter int SQW1_HALF  = SQW1_HALF_DEF,
  parameter int SQW4K_HALF = SQW4K_HALF_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       vcc_good,
  output logic            osc_run,
  output logic            int_out,
  output logic            int_oe,
  output logic            rst_out,
  output logic            rst_oe,
  output logic            square_wave_out,
  output logic            square_wave_oe,
  output logic            charger_enable,
  output logic            charger_diode,
  output logic [1:0]      charger_resistor
);
  typedef enum logic [6:0] {
    LK_IDLE = 7'h01, LK_ADDR = 7'h02, LK_REG = 7'h04, LK_WR = 7'h08,
    LK_RD   = 7'h10, LK_MACK = 7'h20, LK_WAIT = 7'h40
  } rwcs_link_st_t;

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    return (p == ADR_STATUS || p == ADR_CHARGER) ? ADR_FIRST : 8'(p + 8'h01);
  endfunction

  function automatic logic cnt_hit(input logic [7:0] a);
    return (a >= ADR_CNT0) && (a <= ADR_CNT2);
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [7:0] a, input logic [7:0] d);
    logic [23:0] r;
    r = v;
    for (int i = 0; i < 3; i++) begin
      if (a == 8'(ADR_CNT0 + 8'(i))) begin
        r[8*i +: 8] = d;
      end
    end
    return r;
  endfunction

  // =========================================================
  // link side: serial slave on link_clk
  logic [1:0]    pin_meta_ff;
  logic [1:0]    pin_sync_ff;
  logic [1:0]    pin_dly_ff;
  rwcs_link_st_t st_ff;
  logic [3:0]    bitcnt_ff;
  logic [7:0]    shift_ff;
  logic [7:0]    tx_ff;
  logic [7:0]    ptr_ff;
  logic          ackdrv_ff;
  logic          sda_oe_ff;
  logic          req_tgl_ff;
  logic          req_wr_ff;
  logic [7:0]    req_addr_ff;
  logic [7:0]    req_data_ff;
  logic [2:0]    ack_meta_ff;
  logic [7:0]    rbyte_ff;
  logic          ack_tgl_ff;
  logic [7:0]    rdata_ff;

  wire scl_s    = pin_sync_ff[1];
  wire sda_s    = pin_sync_ff[0];
  wire scl_rise = scl_s & ~pin_dly_ff[1];
  wire scl_fall = ~scl_s & pin_dly_ff[1];
  wire bus_hi   = scl_s & pin_dly_ff[1];
  wire start_c  = bus_hi & pin_dly_ff[0] & ~sda_s;
  wire stop_c   = bus_hi & ~pin_dly_ff[0] & sda_s;
  wire byte_in  = (bitcnt_ff == BITS_BYTE);
  wire ack_new  = ack_meta_ff[2] ^ ack_meta_ff[1];

  // pin synchroniser; the first stage feeds only the second
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_ff <= 2'h3;
      pin_sync_ff <= 2'h3;
      pin_dly_ff  <= 2'h3;
    end else begin
      pin_meta_ff <= {scl_in, sda_in};
      pin_sync_ff <= pin_meta_ff;
      pin_dly_ff  <= pin_sync_ff;
    end
  end

  // answer toggle: the data word changes on the same ref_clk edge as the toggle and is stable by the time ack_new sees it
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_meta_ff <= 3'h0;
      rbyte_ff    <= 8'h00;
    end else begin
      ack_meta_ff <= {ack_meta_ff[1:0], ack_tgl_ff};
      if (ack_new) begin
        rbyte_ff <= rdata_ff;
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= LK_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= ADR_FIRST;
      ackdrv_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      req_addr_ff <= ADR_FIRST;
      req_data_ff <= 8'h00;
    end else if (start_c || stop_c) begin
      st_ff <= start_c ? LK_ADDR : LK_IDLE;
      bitcnt_ff <= 4'h0;
      ackdrv_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (scl_rise) begin
      if (st_ff == LK_MACK) begin
        st_ff <= sda_s ? LK_WAIT : LK_MACK;
      end else if ((st_ff == LK_ADDR || st_ff == LK_REG || st_ff == LK_WR) && !byte_in && !ackdrv_ff) begin
        shift_ff <= {shift_ff[6:0], sda_s};
        bitcnt_ff <= 4'(bitcnt_ff + 4'h1);
      end
    end else if (scl_fall) begin
      case (st_ff)
        LK_ADDR, LK_REG, LK_WR: begin
          if (ackdrv_ff) begin
            ackdrv_ff <= 1'b0;
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            if (st_ff == LK_ADDR && shift_ff[0]) begin
              st_ff <= LK_RD;
              sda_oe_ff <= ~rbyte_ff[7];
              tx_ff <= {rbyte_ff[6:0], 1'b1};
              bitcnt_ff <= 4'h1;
            end else if (st_ff == LK_ADDR) begin
              st_ff <= LK_REG;
            end else begin
              st_ff <= LK_WR;
            end
          end else if (byte_in) begin
            ackdrv_ff <= 1'b1;
            sda_oe_ff <= 1'b1;
            if (st_ff == LK_ADDR) begin
              if (shift_ff[7:1] != SLAVE_ADDR) begin
                st_ff <= LK_WAIT;
                ackdrv_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
              end else if (shift_ff[0]) begin
                req_tgl_ff <= ~req_tgl_ff;
                req_wr_ff <= 1'b0;
                req_addr_ff <= ptr_ff;
              end
            end else if (st_ff == LK_REG) begin
              ptr_ff <= shift_ff;
            end else begin
              req_tgl_ff <= ~req_tgl_ff;
              req_wr_ff <= 1'b1;
              req_addr_ff <= ptr_ff;
              req_data_ff <= shift_ff;
              ptr_ff <= ptr_next(ptr_ff);
            end
          end
        end
        LK_RD: begin
          if (byte_in) begin
            st_ff <= LK_MACK;
            sda_oe_ff <= 1'b0;
            ptr_ff <= ptr_next(ptr_ff);
            req_tgl_ff <= ~req_tgl_ff;
            req_wr_ff <= 1'b0;
            req_addr_ff <= ptr_next(ptr_ff);
          end else begin
            sda_oe_ff <= ~tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b1};
            bitcnt_ff <= 4'(bitcnt_ff + 4'h1);
          end
        end
        LK_MACK: begin
          st_ff <= LK_RD;
          sda_oe_ff <= ~rbyte_ff[7];
          tx_ff <= {rbyte_ff[6:0], 1'b1};
          bitcnt_ff <= 4'h1;
        end
        LK_IDLE, LK_WAIT: begin
          sda_oe_ff <= 1'b0;
        end
        default: begin
          st_ff <= LK_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_ff;

  ptr_wrap_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    (scl_fall && !start_c && !stop_c && st_ff == LK_WR && byte_in && !ackdrv_ff && ptr_ff == ADR_STATUS)
    |=> ptr_ff == ADR_FIRST) else $error("pointer did not wrap after last location");

  // =========================================================
  // register side on ref_clk
  logic [2:0]  req_meta_ff;
  logic [1:0]  vcc_meta_ff;
  logic [7:0]  ctrl_ff;
  logic [7:0]  charger_ff;
  logic        osf_ff;
  logic        af_ff;
  logic [23:0] seed_ff;
  logic [23:0] cnt_ff;
  logic        halted_ff;
  logic [31:0] pre_ff;
  logic        pulse_ff;
  logic        pulse_rst_ff;
  logic [31:0] pulse_cnt_ff;
  logic        osc_run_ff;
  logic [31:0] sqw_cnt_ff;
  logic        sqw_ff;
  logic        int_oe_ff;
  logic        rst_oe_ff;
  logic        sqw_oe_ff;
  logic        chg_en_ff;
  logic        chg_diode_ff;
  logic [1:0]  chg_res_ff;

  wire       vcc_s     = vcc_meta_ff[1];
  wire       acc_evt   = req_meta_ff[2] ^ req_meta_ff[1];
  wire       mode_wd   = ctrl_ff[CB_MODE];
  wire       steer     = ctrl_ff[CB_STEER];
  wire       alarm_irq_enable       = ctrl_ff[CB_AIE];
  wire [1:0] rate      = {ctrl_ff[CB_RATE_HI], ctrl_ff[CB_RATE_LO]};
  wire       inhibit   = pulse_ff & pulse_rst_ff;
  wire       acc       = acc_evt & ~inhibit;
  wire       wr        = acc & req_wr_ff;
  wire       wr_ctrl   = wr && req_addr_ff == ADR_CONTROL;
  wire       wr_status = wr && req_addr_ff == ADR_STATUS;
  wire       wr_chg    = wr && req_addr_ff == ADR_CHARGER;
  wire       cnt_acc   = acc && cnt_hit(req_addr_ff);
  wire       cnt_wr    = cnt_acc & req_wr_ff;

  // a zero seed also keeps the counter idle
  wire cnt_run = ctrl_ff[CB_CNT_EN] && seed_ff != CNT_RST && !halted_ff && !pulse_ff && osc_run_ff;
  wire [31:0] tick_len  = mode_wd ? 32'(WD_CYC - 1) : 32'(SEC_CYC - 1);
  wire        tick      = cnt_run && pre_ff >= tick_len;
  wire        zero_evt  = tick && cnt_ff <= 24'h000001;
  wire        pulse_go  = zero_evt & mode_wd & (~steer | alarm_irq_enable);
  wire        pulse_end = pulse_ff && pulse_cnt_ff >= 32'(PULSE_CYC - 1);

  wire [23:0] nxt_seed = cnt_wr ? put_byte(seed_ff, req_addr_ff, req_data_ff) : seed_ff;
  wire [23:0] nxt_cnt  = cnt_wr ? nxt_seed :
                         (cnt_acc && mode_wd) ? seed_ff :
                         (zero_evt && mode_wd) ? CNT_RST :
                         zero_evt ? seed_ff :
                         tick ? 24'(cnt_ff - 24'h000001) : cnt_ff;
  wire        nxt_halted = mode_wd & ~cnt_acc & (halted_ff | zero_evt);
  wire [31:0] nxt_pre    = (!cnt_run || tick) ? 32'h0 : 32'(pre_ff + 32'h1);
  wire        nxt_pulse  = pulse_go | (pulse_ff & ~pulse_end);
  wire [31:0] nxt_pulse_cnt = (pulse_ff && !pulse_end) ? 32'(pulse_cnt_ff + 32'h1) : 32'h0;
  wire        nxt_pulse_rst = pulse_go ? ~steer : pulse_rst_ff;

  // set wins over a software clear in the same cycle
  wire nxt_af  = zero_evt | (af_ff & ~(wr_status & ~req_data_ff[SB_AF]) & ~pulse_end);
  wire nxt_osc = ~(ctrl_ff[CB_OSC_DIS] & ~vcc_s);
  wire nxt_osf = (osc_run_ff & ~nxt_osc) | (osf_ff & ~(wr_status & ~req_data_ff[SB_OSF]));

  wire [7:0] rd_data = (req_addr_ff == ADR_CONTROL) ? ctrl_ff :
                       (req_addr_ff == ADR_STATUS)  ? {osf_ff, 6'h00, af_ff} :
                       (req_addr_ff == ADR_CHARGER) ? charger_ff :
                       cnt_hit(req_addr_ff) ? cnt_ff[8*(req_addr_ff - ADR_CNT0) +: 8] : 8'h00;

  wire [31:0] sqw_half = (rate == RATE_1HZ) ? 32'(SQW1_HALF - 1) :
                         (rate == RATE_4K)  ? 32'(SQW4K_HALF - 1) :
                         (rate == RATE_8K)  ? 32'(SQW8K_HALF - 1) : 32'(SQW32K_HALF - 1);
  wire        sqw_wrap = osc_run_ff && sqw_cnt_ff >= sqw_half;
  wire [31:0] nxt_sqw_cnt = !osc_run_ff ? sqw_cnt_ff : sqw_wrap ? 32'h0 : 32'(sqw_cnt_ff + 32'h1);

  wire       chg_ds_ok = charger_ff[3:2] == DIODE_NONE || charger_ff[3:2] == DIODE_ONE;
  wire       nxt_chg_en = charger_ff[7:4] == UNLOCK_KEY && chg_ds_ok && charger_ff[1:0] != RES_OFF;
  // periodic mode ignores steer; watchdog mode only signals through the pulse
  wire       nxt_int_oe = (~mode_wd & alarm_irq_enable & af_ff) | (pulse_ff & ~pulse_rst_ff);
  wire       nxt_rst_oe = inhibit | ~vcc_s;
  wire       nxt_sqw_oe = vcc_s | ctrl_ff[CB_BACKUP_SQUARE_WAVE_ENABLE];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_meta_ff <= 3'h0;
      vcc_meta_ff <= 2'h0;
      ack_tgl_ff  <= 1'b0;
      rdata_ff    <= 8'h00;
    end else begin
      req_meta_ff <= {req_meta_ff[1:0], req_tgl_ff};
      vcc_meta_ff <= {vcc_meta_ff[0], vcc_good};
      ack_tgl_ff  <= ack_tgl_ff ^ acc_evt;
      rdata_ff    <= acc ? rd_data : (acc_evt ? 8'h00 : rdata_ff);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= CONTROL_RST;
      charger_ff <= CHARGER_RST;
      osf_ff     <= OSF_RST;
      af_ff      <= 1'b0;
      seed_ff    <= CNT_RST;
      cnt_ff     <= CNT_RST;
      halted_ff  <= 1'b0;
      pre_ff     <= 32'h0;
    end else begin
      ctrl_ff    <= wr_ctrl ? req_data_ff : ctrl_ff;
      charger_ff <= wr_chg ? req_data_ff : charger_ff;
      osf_ff     <= nxt_osf;
      af_ff      <= nxt_af;
      seed_ff    <= nxt_seed;
      cnt_ff     <= nxt_cnt;
      halted_ff  <= nxt_halted;
      pre_ff     <= nxt_pre;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_ff     <= 1'b0;
      pulse_rst_ff <= 1'b0;
      pulse_cnt_ff <= 32'h0;
      osc_run_ff   <= 1'b1;
      sqw_cnt_ff   <= 32'h0;
      sqw_ff       <= 1'b0;
    end else begin
      pulse_ff     <= nxt_pulse;
      pulse_rst_ff <= nxt_pulse_rst;
      pulse_cnt_ff <= nxt_pulse_cnt;
      osc_run_ff   <= nxt_osc;
      sqw_cnt_ff   <= nxt_sqw_cnt;
      sqw_ff       <= sqw_ff ^ sqw_wrap;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_oe_ff    <= 1'b0;
      rst_oe_ff    <= 1'b0;
      sqw_oe_ff    <= 1'b0;
      chg_en_ff    <= 1'b0;
      chg_diode_ff <= 1'b0;
      chg_res_ff   <= RES_OFF;
    end else begin
      int_oe_ff    <= nxt_int_oe;
      rst_oe_ff    <= nxt_rst_oe;
      sqw_oe_ff    <= nxt_sqw_oe;
      chg_en_ff    <= nxt_chg_en;
      chg_diode_ff <= nxt_chg_en & (charger_ff[3:2] == DIODE_ONE);
      chg_res_ff   <= nxt_chg_en ? charger_ff[1:0] : RES_OFF;
    end
  end

  assign osc_run          = osc_run_ff;
  assign int_out          = 1'b0;
  assign int_oe           = int_oe_ff;
  assign rst_out          = 1'b0;
  assign rst_oe           = rst_oe_ff;
  assign square_wave_out  = sqw_ff;
  assign square_wave_oe   = sqw_oe_ff;
  assign charger_enable   = chg_en_ff;
  assign charger_diode    = chg_diode_ff;
  assign charger_resistor = chg_res_ff;

  // =========================================================
  // checks
  osc_main_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    vcc_s |=> osc_run_ff) else $error("oscillator stopped on main supply");
  osc_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ctrl_ff[CB_OSC_DIS] && !vcc_s) |=> !osc_run_ff) else $error("oscillator runs while disabled on backup");
  osf_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(osc_run_ff) |-> osf_ff) else $error("stopped flag not set");
  periodic_reload_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zero_evt && !mode_wd && !cnt_acc) |=> cnt_ff == $past(seed_ff)) else $error("periodic reload missing");
  wd_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zero_evt && mode_wd && !cnt_acc) |=> (af_ff && halted_ff && cnt_ff == CNT_RST)) else $error("watchdog halt wrong");
  rst_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zero_evt && mode_wd && !steer) |-> ##2 rst_oe_ff) else $error("reset pulse missing");
  pulse_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pulse_ff && pulse_cnt_ff < 32'(PULSE_CYC - 1)) |=> pulse_ff) else $error("pulse cut short");
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zero_evt && mode_wd && !alarm_irq_enable) |=> !(pulse_ff && !pulse_rst_ff)) else $error("interrupt pulse without enable");
  af_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_status && req_data_ff[SB_AF] && !zero_evt && !pulse_end) |=> af_ff == $past(af_ff))
    else $error("alarm flag changed by write of 1");
  chg_key_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    chg_en_ff |-> $past(charger_ff[7:4]) == UNLOCK_KEY) else $error("charger on without unlock");
endmodule

// ===== testbench/rwcs_host.sv
// two-wire bus host model: drives scl, pulls sda low, reports read bytes
// assumes a pull-up on sda; the bench resolves sda_line from all pulls
module rwcs_host
  import rwcs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_pull,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // =========================================
  // bit timing: quarter of 25 cycles gives 400 kHz
  localparam int QTR = 25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic wq();
    repeat (QTR) @(posedge ref_clk);
  endtask
  // sda moves only while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    wq();
    scl <= 1'b1;
    wq();
    r = sda_line;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(mack, b);
  endtask
  task automatic start();
    sda_pull <= 1'b0;
    wq();
    scl <= 1'b1;
    wq();
    sda_pull <= 1'b1;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  // scl stays high after stop: the clock stands still between frames
  task automatic stop();
    sda_pull <= 1'b1;
    wq();
    scl <= 1'b1;
    wq();
    sda_pull <= 1'b0;
    wq();
  endtask
  task automatic hdr(input logic [7:0] p);
    logic [7:0] r;
    start();
    xfer({SLAVE_ADDR, 1'b0}, 1'b1, r);
    xfer(p, 1'b1, r);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic [7:0] r;
    hdr(p);
    foreach (d[i]) xfer(d[i], 1'b1, r);
    stop();
  endtask
  // last byte is not acknowledged to end the read
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] r;
    hdr(p);
    start();
    xfer({SLAVE_ADDR, 1'b1}, 1'b1, r);
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, logic'(i == n - 1), r);
      rd_data <= r;
      rd_valid <= 1'b1;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
    end
    stop();
  endtask
endmodule

// ===== testbench/tb_rtc_watchdog_control_status_regs.sv
// bench for the control, status and charger registers
// assumes the host model and shortened counts for the timebase
module tb_rtc_watchdog_control_status_regs
  import rwcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PC = 20;
  localparam int S1 = 8;
  localparam int S4 = 6;
  logic ref_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, vcc_good = 1'b1;
  logic scl, sda_pull, rd_valid, sda_out, sda_oe, int_oe, rst_oe, osc_run;
  logic charger_enable, charger_diode, int_out, rst_out, square_wave_out, square_wave_oe;
  logic [1:0] charger_resistor;
  logic [7:0] rd_data;
  logic [31:0] pw = '0;
  int fail_count = 0, checks_done = 0;
  logic [7:0] rq[$];
  int pq[$];
  wire sda_line = ~(sda_pull | (sda_oe & ~sda_out));
  // =========================================
  // clocks, model and design
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  rwcs_host i_rwcs_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull),
    .rd_valid(rd_valid), .rd_data(rd_data));
  rwcs_regs #(.SEC_CYC(40), .WD_CYC(10), .PULSE_CYC(PC), .SQW1_HALF(S1), .SQW4K_HALF(S4)) i_rwcs_regs (
    .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .vcc_good(vcc_good), .osc_run(osc_run), .int_out(int_out),
    .int_oe(int_oe), .rst_out(rst_out), .rst_oe(rst_oe), .square_wave_out(square_wave_out),
    .square_wave_oe(square_wave_oe),
    .charger_enable(charger_enable), .charger_diode(charger_diode), .charger_resistor(charger_resistor));
  // =========================================
  // checking
  task automatic compare(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) if (rd_valid) compare(rd_data, rq.pop_front());
  // widths seen with no note queued (supply loss) are ignored
  always @(posedge ref_clk) begin
    if (int_oe | rst_oe) pw <= pw + 1;
    else if (pw != 0) begin
      if (pq.size() != 0) compare(pw, pq.pop_front());
      pw <= '0;
    end
  end
  task automatic wait_pulse();
    for (int i = 0; i < 3000 && pq.size() != 0; i++) @(posedge ref_clk);
    compare(pq.size(), 0);
  endtask
  // half period in ref_clk cycles, taken between two toggles of the square wave
  task automatic sqw_check(input int e);
    int n;
    logic s;
    n = 0;
    s = square_wave_out;
    while (square_wave_out == s) @(posedge ref_clk);
    s = square_wave_out;
    while (square_wave_out == s) begin
      @(posedge ref_clk);
      n++;
    end
    compare(n, e);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
  // =========================================
  // scenarios
  initial begin
    logic [7:0] v;
    logic en;
    void'($urandom(32'h44ea));
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rq.push_back(CONTROL_RST);
    rq.push_back(8'h80);
    rq.push_back(8'h00);
    i_rwcs_host.rd(ADR_CONTROL, 3);
    sqw_check(SQW32K_HALF);
    rq.push_back(CHARGER_RST);
    i_rwcs_host.rd(ADR_CHARGER, 1);
    i_rwcs_host.wr(ADR_STATUS, '{8'h00});
    rq.push_back(8'h00);
    i_rwcs_host.rd(ADR_STATUS, 1);
    for (int k = 0; k < 3; k++) begin
      v = {(k == 2) ? 4'($urandom) : UNLOCK_KEY, (k == 0) ? 4'h6 : 4'($urandom)};
      en = v[7:4] == UNLOCK_KEY && (v[3:2] == DIODE_NONE || v[3:2] == DIODE_ONE) && v[1:0] != RES_OFF;
      i_rwcs_host.wr(ADR_CHARGER, '{v});
      compare(charger_enable, en);
      if (en) compare(charger_diode, v[3:2] == DIODE_ONE);
      if (en) compare(charger_resistor, v[1:0]);
      rq.push_back(v);
      i_rwcs_host.rd(ADR_CHARGER, 1);
    end
    pq.push_back(PC);
    i_rwcs_host.wr(ADR_CNT0, '{8'h03, 8'h00, 8'h00, 8'h60});
    wait_pulse();
    // seed of 512 ticks outlasts each gap between counter reads but not the whole span
    i_rwcs_host.wr(ADR_CNT0, '{8'h00, 8'h02, 8'h00, 8'h68});
    rq.push_back(8'h00);
    i_rwcs_host.rd(ADR_CNT2, 1);
    rq.push_back(8'h00);
    i_rwcs_host.rd(ADR_STATUS, 1);
    i_rwcs_host.wr(ADR_CONTROL, '{8'h29});
    pq.push_back(PC);
    i_rwcs_host.wr(ADR_CNT0, '{8'h03, 8'h00, 8'h00, 8'h69});
    wait_pulse();
    rq.push_back(8'h00);
    i_rwcs_host.rd(ADR_STATUS, 1);
    i_rwcs_host.wr(ADR_CONTROL, '{8'h43});
    compare(int_oe, 1'b1);
    sqw_check(S4);
    rq.push_back(8'h01);
    i_rwcs_host.rd(ADR_STATUS, 1);
    i_rwcs_host.wr(ADR_CONTROL, '{8'h01});
    compare(int_oe, 1'b1);
    i_rwcs_host.wr(ADR_STATUS, '{8'h00});
    compare(int_oe, 1'b0);
    i_rwcs_host.wr(ADR_CONTROL, '{8'h80});
    compare(osc_run, 1'b1);
    compare(square_wave_oe, 1'b1);
    sqw_check(S1);
    vcc_good <= 1'b0;
    repeat (10) @(posedge ref_clk);
    compare(osc_run, 1'b0);
    compare(square_wave_oe, 1'b0);
    vcc_good <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rq.push_back(8'h80);
    i_rwcs_host.rd(ADR_STATUS, 1);
    compare(int_out, 1'b0);
    compare(rst_out, 1'b0);
    give_verdict();
  end
endmodule
